// >>> lbc_regs.svh
// constants of the led boost control sequencer
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH
`define LBC_CLK_HZ          200000000
`define LBC_SW_HZ           600000
`define LBC_SW_DIV          (`LBC_CLK_HZ / `LBC_SW_HZ)
`define LBC_RAMP_STEPS      32
`define LBC_STEP_US         213
`define LBC_STEP_CYC        ((`LBC_STEP_US * `LBC_SW_HZ) / 1000000)
`define LBC_HALF_LIM_US     5000
// scaled to kHz first so the product stays inside a 32-bit int
`define LBC_HALF_LIM_CYC    ((`LBC_HALF_LIM_US * (`LBC_SW_HZ / 1000) + 999) / 1000)
`define LBC_OFF_US          2500
`define LBC_OFF_CYC         ((`LBC_OFF_US * 200) + 1)
`define LBC_OPEN_CYC        8
`define LBC_REF_FULL        8'hFF
`define LBC_FILT_SHIFT      4
`endif

// >>> lbc_pkg.sv
// types of the led boost control sequencer
package lbc_pkg;
  typedef enum logic [1:0] {
    lbc_off, lbc_soft, lbc_run, lbc_latched
  } lbc_state_type;
endpackage

// >>> lbc_sequencer.sv
// led boost control sequencer: enable, soft start, faults, dimming reference
//
// Behaviour
// - switching cycles from fixed 600 kHz tick
// - ramp reference in 32 steps, 213 us
// - half current limit for first 5 ms
// - open string after 8 cycles both qualifiers
// - qualifiers: switch node high, feedback below half
// - open string latched until control toggles
// - shutdown only after low over 2.5 ms
// - no gate drive while in shutdown
// - steady high control gives full reference
// - chop reference by control, low-pass filter
// - reference depends on duty only
// - low supply holds shutdown, auto restart
// - over temperature shuts down, auto resume
// - enable always runs soft start first
`include "lbc_regs.svh"
module lbc_sequencer
  import lbc_pkg::*;
#(
  parameter int unsigned OFF_CYC  = `LBC_OFF_CYC,
  parameter int unsigned SW_DIV   = `LBC_SW_DIV,
  parameter int unsigned STEP_CYC = `LBC_STEP_CYC,
  parameter int unsigned HALF_CYC = `LBC_HALF_LIM_CYC
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // control input and analog flags
  input  wire logic       ctrl_in,
  input  wire logic       switch_node_over,
  input  wire logic       feedback_sense_low,
  input  wire logic       low_supply_lockout,
  input  wire logic       over_temp,
  // power stage controls
  output logic            gate_enable,
  output logic            half_limit,
  output logic [7:0]      reg_reference,
  output logic [7:0]      half_reference,
  output logic            switch_tick,
  output logic            open_fault,
  output logic            active
);

  // ****************************************
  // parameter limits
  // ****************************************
  // counters are sized for the documented counts; refuse anything that
  // would overflow them or leave no idle clock between two ticks
  if (SW_DIV < 2 || SW_DIV > 65536) begin : g_bad_div
    $error("lbc_sequencer: SW_DIV out of range");
  end
  if (STEP_CYC < 1 || STEP_CYC > 1024) begin : g_bad_step
    $error("lbc_sequencer: STEP_CYC out of range");
  end
  if (HALF_CYC < 1 || HALF_CYC > 8191) begin : g_bad_half
    $error("lbc_sequencer: HALF_CYC out of range");
  end
  if (OFF_CYC < 2 || OFF_CYC > 1048575) begin : g_bad_off
    $error("lbc_sequencer: OFF_CYC out of range");
  end

  // ****************************************
  // synchronisers
  // ****************************************
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  // second stage only is read downstream
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {ctrl_in, switch_node_over, feedback_sense_low,
                 low_supply_lockout, over_temp};
      sync_b <= sync_a;
    end
  end
  logic ctrl_s, sw_s, fb_s, uv_s, ot_s;
  assign {ctrl_s, sw_s, fb_s, uv_s, ot_s} = sync_b;

  // ****************************************
  // switching tick
  // ****************************************
  logic [15:0] div_cnt;
  // one pulse per switching period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt     <= 16'h0000;
      switch_tick <= 1'b0;
    end else if (div_cnt == 16'(SW_DIV - 1)) begin
      div_cnt     <= 16'h0000;
      switch_tick <= 1'b1;
    end else begin
      div_cnt     <= div_cnt + 16'h0001;
      switch_tick <= 1'b0;
    end
  end

  // ****************************************
  // disable detection
  // ****************************************
  logic [19:0] low_cnt;
  logic        ctrl_low_long;
  // low pulses shorter than the window are just dimming
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 20'h00000;
    end else if (ctrl_s) begin
      low_cnt <= 20'h00000;
    end else if (low_cnt != 20'(OFF_CYC)) begin
      low_cnt <= low_cnt + 20'h00001;
    end
  end
  assign ctrl_low_long = (low_cnt == 20'(OFF_CYC));

  // ****************************************
  // main state machine
  // ****************************************
  lbc_state_type state;
  logic          fault_hit;
  logic          ramp_done;
  logic          inhibit;
  assign inhibit = uv_s | ot_s;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= lbc_off;
    end else begin
      unique case (state)
        lbc_off: begin
          // enable needs a high control and healthy supply
          if (ctrl_s && !inhibit)
            state <= lbc_soft;
        end
        lbc_soft, lbc_run: begin
          if (ctrl_low_long || inhibit)
            state <= lbc_off;
          else if (fault_hit)
            state <= lbc_latched;
          else if (state == lbc_soft && ramp_done)
            state <= lbc_run;
        end
        lbc_latched: begin
          // only a real disable releases the latch
          if (ctrl_low_long)
            state <= lbc_off;
        end
      endcase
    end
  end
  assign active      = (state == lbc_soft) || (state == lbc_run);
  assign gate_enable = active;
  assign open_fault  = (state == lbc_latched);

  // ****************************************
  // open string detection
  // ****************************************
  logic [3:0] open_cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      open_cnt <= 4'h0;
    end else if (!active) begin
      open_cnt <= 4'h0;
    end else if (switch_tick) begin
      if (sw_s && fb_s)
        open_cnt <= open_cnt + 4'h1;
      else
        open_cnt <= 4'h0;
    end
  end
  assign fault_hit = (open_cnt == 4'(`LBC_OPEN_CYC));

  // ****************************************
  // soft start ramp and half limit window
  // ****************************************
  logic [9:0]  step_cnt;
  logic [5:0]  step_idx;
  logic [12:0] half_cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_cnt <= 10'h000;
      step_idx <= 6'h00;
    end else if (!active) begin
      step_cnt <= 10'h000;
      step_idx <= 6'h00;
    end else if (switch_tick && step_idx != 6'(`LBC_RAMP_STEPS)) begin
      if (step_cnt == 10'(STEP_CYC - 1)) begin
        step_cnt <= 10'h000;
        step_idx <= step_idx + 6'h01;
      end else begin
        step_cnt <= step_cnt + 10'h001;
      end
    end
  end
  assign ramp_done = (step_idx == 6'(`LBC_RAMP_STEPS));

  // window counted in switching cycles from enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      half_cnt <= 13'h0000;
    end else if (!active) begin
      half_cnt <= 13'h0000;
    end else if (switch_tick && half_cnt != 13'(HALF_CYC)) begin
      half_cnt <= half_cnt + 13'h0001;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      half_limit <= 1'b0;
    else
      half_limit <= active && (half_cnt != 13'(HALF_CYC));
  end

  // ****************************************
  // dimming reference
  // ****************************************
  // chopped level uses only the synchronised logic bit, never voltage
  logic [7:0]  chop;
  logic [15:0] filt;
  logic [15:0] next_filt;
  logic [7:0]  ramp_cap;
  assign chop = ctrl_s ? `LBC_REF_FULL : 8'h00;
  // single-pole filter: trades settling time for low ripple
  always_comb begin
    next_filt = filt - (filt >> `LBC_FILT_SHIFT)
              + ({8'h00, chop} << (8 - `LBC_FILT_SHIFT));
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      filt <= 16'h0000;
    else if (switch_tick)
      filt <= next_filt;
  end
  assign ramp_cap = ramp_done ? `LBC_REF_FULL
                  : 8'({step_idx, 3'b000});
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_reference  <= 8'h00;
      half_reference <= 8'h00;
    end else if (!active) begin
      reg_reference  <= 8'h00;
      half_reference <= 8'h00;
    end else begin
      reg_reference  <= (filt[15:8] < ramp_cap) ? filt[15:8] : ramp_cap;
      half_reference <= {1'b0, reg_reference[7:1]};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_gate_off_shut: assert property (
    @(posedge core_clk) disable iff (rst)
    (state == lbc_off || state == lbc_latched) |-> !gate_enable)
    else $error("gate active in shutdown");
  chk_open_latch: assert property (
    @(posedge core_clk) disable iff (rst)
    fault_hit && active && !ctrl_low_long && !inhibit
    |=> state == lbc_latched)
    else $error("open string not latched");
  chk_latch_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    state == lbc_latched && !ctrl_low_long |=> state == lbc_latched)
    else $error("latch released without toggle");
  chk_inhibit_off: assert property (
    @(posedge core_clk) disable iff (rst)
    inhibit && active |=> state == lbc_off)
    else $error("inhibit did not shut down");
  chk_enable_soft: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(active) |-> step_idx == 6'h00 && half_cnt == 13'h0000)
    else $error("ramp not reset");
  chk_short_low: assert property (
    @(posedge core_clk) disable iff (rst)
    active && low_cnt < 20'(OFF_CYC - 1) && !inhibit && !fault_hit
    |=> state != lbc_off)
    else $error("short low pulse shut down");
  chk_half_start: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(active) |=> ##1 half_limit)
    else $error("half limit missing");
  chk_count_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    switch_tick && active && !(sw_s && fb_s) |=> open_cnt == 4'h0)
    else $error("open counter not cleared");
  chk_soft_first: assert property (
    @(posedge core_clk) disable iff (rst)
    state == lbc_off ##1 active |-> state == lbc_soft)
    else $error("enable skipped soft start");
  chk_tick_single: assert property (
    @(posedge core_clk) disable iff (rst)
    switch_tick |=> !switch_tick)
    else $error("switching tick longer than one clock");
  // main scenarios: ramp, open string, disable, inhibit, dimming low phase
  cov_ramp_done: cover property (@(posedge core_clk) $rose(ramp_done));
  cov_open: cover property (@(posedge core_clk) $rose(open_fault));
  cov_disable: cover property (@(posedge core_clk)
    state == lbc_run ##1 state == lbc_off);
  cov_inhibit: cover property (@(posedge core_clk)
    $rose(inhibit) && active);
  cov_dim_low: cover property (@(posedge core_clk)
    active && $fell(ctrl_s));
endmodule

// >>> lbc_host_model.sv
// host brightness source driving the control input of the sequencer
module lbc_host_model (
  // clock from the bench, drives on the falling edge
  input  wire logic       core_clk,
  // mode, steady level and pwm shape in clocks
  input  wire logic       pwm_on,
  input  wire logic       level,
  input  wire logic [7:0] high_cyc,
  input  wire logic [7:0] period_cyc,
  // control pin
  output logic            ctrl_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  initial ctrl_in = 1'b0;
  // ******************************************
  // clean full-swing logic only, never a filtered analog level
  // ******************************************
  // pwm period is kept short: low phases must never read as disable;
  // 6 to 120 switching ticks a period keeps the host inside its rate band
  always @(negedge core_clk) begin
    if (!pwm_on) begin
      cnt     <= 8'h00;
      ctrl_in <= level;
    end else begin
      cnt     <= (cnt + 8'h01 == period_cyc) ? 8'h00 : cnt + 8'h01;
      ctrl_in <= (cnt < high_cyc);
    end
  end
endmodule

// >>> lbc_sequencer_tb.sv
// self-checking bench of the led boost control sequencer
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module lbc_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 0, rst = 1, sw_over = 0, fb_low = 0;
  logic       lockout = 0, hot = 0, pwm_on = 0, level = 0;
  logic [7:0] hi_cyc = 8'h10, per_cyc = 8'h20;
  logic       ctrl_in, gate_enable, half_limit, switch_tick;
  logic       open_fault, active;
  logic [7:0] reg_reference, half_reference;
  int         miscompares = 0, comparisons = 0;
  // ******************************************
  // clock, design and host
  // ******************************************
  initial forever #2.5 core_clk = ~core_clk;
  // short counts keep the run brief: off 50, tick 4, step 2, window 10
  lbc_sequencer #(.OFF_CYC(50), .SW_DIV(4), .STEP_CYC(2), .HALF_CYC(10))
    dut_u (.core_clk(core_clk), .rst(rst), .ctrl_in(ctrl_in),
    .switch_node_over(sw_over), .feedback_sense_low(fb_low),
    .low_supply_lockout(lockout), .over_temp(hot),
    .gate_enable(gate_enable), .half_limit(half_limit),
    .reg_reference(reg_reference), .half_reference(half_reference),
    .switch_tick(switch_tick), .open_fault(open_fault), .active(active));
  lbc_host_model host_u (.core_clk(core_clk), .pwm_on(pwm_on),
    .level(level), .high_cyc(hi_cyc), .period_cyc(per_cyc),
    .ctrl_in(ctrl_in));
  // ******************************************
  // scenarios
  // ******************************************
  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // enable: soft start, half limit window, full reference
  task automatic t_enable;
    int ticks = 0;
    level = 1;
    wait_clk(6);
    `CHK("active", 1'b1, active)
    `CHK("gate", 1'b1, gate_enable)
    `CHK("half_lim", 1'b1, half_limit)
    `CHK("ramp_low", 1'b1, reg_reference < 8'h20)
    // ten one-clock ticks in forty clocks at the shortened divider
    repeat (40) begin
      @(negedge core_clk);
      if (switch_tick === 1'b1)
        ticks++;
    end
    `CHK("ticks", 32'd10, ticks)
    wait_clk(14);
    `CHK("half_end", 1'b0, half_limit)
    wait_clk(600);
    `CHK("ref_full", 1'b1, reg_reference >= 8'hF0)
    `CHK("half_ref", reg_reference >> 1, half_reference)
  endtask
  // half then quarter duty pwm, 8 ticks a period: reference follows duty
  task automatic t_pwm;
    pwm_on = 1;
    wait_clk(800);
    `CHK("pwm_act", 1'b1, active)
    `CHK("pwm_ref", 1'b1, reg_reference inside {[8'h50:8'hB0]})
    hi_cyc = 8'h08;
    wait_clk(800);
    `CHK("pwm_act2", 1'b1, active)
    `CHK("pwm_ref2", 1'b1, reg_reference inside {[8'h28:8'h58]})
    pwm_on = 0;
    wait_clk(400);
  endtask
  // long low only shuts down; short one is ignored
  task automatic t_disable;
    level = 0;
    wait_clk(40);
    `CHK("short_low", 1'b1, active)
    wait_clk(30);
    `CHK("off_act", 1'b0, active)
    `CHK("off_gate", 1'b0, gate_enable)
  endtask
  // open string: one qualifier alone, then both, then latch and toggle
  task automatic t_open;
    sw_over = 1;
    wait_clk(60);
    `CHK("one_qual", 1'b0, open_fault)
    fb_low = 1;
    wait_clk(31);
    `CHK("early", 1'b0, open_fault)
    wait_clk(30);
    `CHK("open", 1'b1, open_fault)
    `CHK("open_gate", 1'b0, gate_enable)
    sw_over = 0;
    fb_low = 0;
    wait_clk(100);
    `CHK("latched", 1'b1, open_fault)
    level = 0;
    wait_clk(40);
    `CHK("short_rel", 1'b1, open_fault)
    wait_clk(30);
    `CHK("released", 1'b0, open_fault)
    `CHK("rel_gate", 1'b0, gate_enable)
    level = 1;
    wait_clk(6);
    `CHK("re_act", 1'b1, active)
    `CHK("re_half", 1'b1, half_limit)
    `CHK("re_ramp", 1'b1, reg_reference < 8'h20)
    wait_clk(660);
  endtask
  // lockout and over temperature hold off, resume via soft start
  task automatic t_inhibit;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) lockout = 1; else hot = 1;
      wait_clk(5);
      `CHK("inh_act", 1'b0, active)
      `CHK("inh_gate", 1'b0, gate_enable)
      lockout = 0;
      hot = 0;
      wait_clk(6);
      `CHK("resume", 1'b1, active)
      `CHK("res_half", 1'b1, half_limit)
      wait_clk(660);
    end
  endtask
  // ******************************************
  // sequence, watchdog and verdict
  // ******************************************
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    wait_clk(16);
    rst = 0;
    wait_clk(2);
    t_enable();
    t_pwm();
    t_disable();
    t_enable();
    t_open();
    t_inhibit();
    print_verdict();
  end
  // whole run needs about 30 us; a hang is cut well beyond that
  initial begin
    #100us;
    miscompares++;
    print_verdict();
  end
endmodule
